// File: inc/ppem_pkg.sv
// Package: register map, field layout and types of the port parity error monitor
package ppem_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_TEST_CTRL = 12'h4d4;
  localparam logic [11:0] OFF_ERR_STATUS = 12'h4d8;
  localparam logic [11:0] OFF_ERR_REPORT = 12'h4dc;
  localparam logic [11:0] OFF_ERR_COUNT = 12'h4e0;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h4f0;

  // ==========================================================================
  // Field positions
  localparam int unsigned BIT_CHECK_DIS = 0;
  localparam int unsigned BIT_INJECT = 1;
  localparam int unsigned LEN_LSB = 8;
  localparam int unsigned LEN_MSB = 15;
  localparam int unsigned BIT_PERR_FLAG = 0;
  localparam int unsigned CLASS_LSB = 0;
  localparam int unsigned CLASS_MSB = 1;
  localparam int unsigned BIT_IRQ_EN = 2;
  localparam int unsigned CNT_LSB = 0;
  localparam int unsigned CNT_MSB = 7;
  localparam int unsigned HDR_LEN_LSB = 24;
  localparam int unsigned HDR_LEN_MSB = 31;

  // ==========================================================================
  // Reset values and limits
  localparam logic [7:0] LEN_RST = 8'h00;
  localparam logic [1:0] CLASS_RST = 2'h2;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic MASK_RST = 1'b0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PPEM_REP_NONE = 2'h0,
    PPEM_REP_COR = 2'h1,
    PPEM_REP_NONFATAL = 2'h2,
    PPEM_REP_FATAL = 2'h3
  } ppem_report_e;

  typedef enum logic [1:0] {
    PPEM_PK_IDLE = 2'b01,
    PPEM_PK_BODY = 2'b10
  } ppem_pkt_e;

  // One double word with framing and its end-to-end parity bit
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [31:0] data;
    logic par;
  } ppem_dw_s;

endpackage : ppem_pkg

// File: logic/ppem_monitor.sv
// Port parity error monitor: check, generate, inject, count and report
`timescale 1ns/10ps

module ppem_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ppem_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire ppem_pkg::ppem_dw_s core_rx_i,
  input wire ppem_pkg::ppem_dw_s port_tx_i,
  output ppem_pkg::ppem_dw_s core_tx_o,
  input wire logic upstream_irq_en_i,
  output logic err_msg_valid_o,
  output logic [1:0] err_msg_class_o,
  output logic irq_o
);
  import ppem_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic dw_parity(input logic [31:0] d);
    dw_parity = ^d;
  endfunction : dw_parity

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  // ==========================================================================
  // Elaboration checks on the register layout
  if (ADDR_W != 12) begin : g_chk_addr
    $error("Register offsets need a 12-bit address");
  end
  if (LEN_MSB - LEN_LSB != 7) begin : g_chk_len
    $error("Match length field must be 8 bits wide");
  end
  if (HDR_LEN_MSB - HDR_LEN_LSB != 7) begin : g_chk_hdr
    $error("Header length byte must be 8 bits wide");
  end
  if (CNT_MSB - CNT_LSB != 7) begin : g_chk_cnt
    $error("Error counter field must be 8 bits wide");
  end
  if (CLASS_MSB - CLASS_LSB != 1) begin : g_chk_class
    $error("Report class field must be 2 bits wide");
  end
  if (BIT_IRQ_EN <= CLASS_MSB) begin : g_chk_irq_en
    $error("Interrupt enable bit overlaps the report class");
  end
  if (LEN_LSB <= BIT_INJECT) begin : g_chk_ctrl
    $error("Match length overlaps the control bits");
  end

  // ==========================================================================
  // Register state
  logic check_dis;
  logic inject;
  logic [7:0] match_len;
  logic perr_flag;
  logic [1:0] report_class;
  logic irq_en;
  logic irq_mask;
  logic [7:0] perr_cnt;
  logic [31:0] rdata;
  logic next_check_dis;
  logic next_inject;
  logic [7:0] next_match_len;
  logic next_perr_flag;
  logic [1:0] next_report_class;
  logic next_irq_en;
  logic next_irq_mask;
  logic [7:0] next_perr_cnt;
  logic [31:0] next_rdata;

  // ==========================================================================
  // Reporting state
  logic msg_valid;
  logic [1:0] msg_class;
  logic next_msg_valid;
  logic [1:0] next_msg_class;

  // ==========================================================================
  // Generation path state
  ppem_pkt_e pkt_state;
  ppem_pkt_e next_pkt_state;
  logic corrupt_hold;
  logic next_corrupt_hold;
  ppem_dw_s tx_q;
  ppem_dw_s next_tx_q;

  logic wr_ctrl;
  logic wr_stat;
  logic wr_rep;
  logic wr_mask;
  logic rd_cnt;
  logic err_det;
  logic flag_rise;
  logic corrupt_now;

  assign wr_ctrl = reg_wr_i && reg_hit(reg_addr_i, OFF_TEST_CTRL);
  assign wr_stat = reg_wr_i && reg_hit(reg_addr_i, OFF_ERR_STATUS);
  assign wr_rep = reg_wr_i && reg_hit(reg_addr_i, OFF_ERR_REPORT);
  assign wr_mask = reg_wr_i && reg_hit(reg_addr_i, OFF_IRQ_MASK);
  assign rd_cnt = reg_rd_i && reg_hit(reg_addr_i, OFF_ERR_COUNT);

  // ==========================================================================
  // Check path: double words from the core
  always_comb begin
    err_det = 1'b0;
    if (core_rx_i.valid && !check_dis) begin
      err_det = (core_rx_i.par != dw_parity(core_rx_i.data));
    end
  end

  assign flag_rise = err_det && !perr_flag;

  // ==========================================================================
  // Register next values
  always_comb begin
    next_check_dis = check_dis;
    next_inject = inject;
    next_match_len = match_len;
    next_perr_flag = perr_flag;
    next_report_class = report_class;
    next_irq_en = irq_en;
    next_irq_mask = irq_mask;
    next_perr_cnt = perr_cnt;
    // Read data stand one cycle, zero otherwise
    next_rdata = 32'h0000_0000;
    if (wr_ctrl) begin
      next_check_dis = reg_wdata_i[BIT_CHECK_DIS];
      next_inject = reg_wdata_i[BIT_INJECT];
      next_match_len = reg_wdata_i[LEN_MSB:LEN_LSB];
    end
    if (wr_rep) begin
      next_report_class = reg_wdata_i[CLASS_MSB:CLASS_LSB];
      next_irq_en = reg_wdata_i[BIT_IRQ_EN];
    end
    if (wr_mask) begin
      next_irq_mask = reg_wdata_i[BIT_PERR_FLAG];
    end
    // Set wins over a same-cycle write-one-to-clear
    if (wr_stat && reg_wdata_i[BIT_PERR_FLAG]) begin
      next_perr_flag = 1'b0;
    end
    if (err_det) begin
      next_perr_flag = 1'b1;
    end
    // Read clears; an error in the same cycle is counted afterwards
    if (rd_cnt) begin
      next_perr_cnt = 8'h00;
    end
    if (err_det) begin
      if (rd_cnt) begin
        next_perr_cnt = 8'h01;
      end else if (perr_cnt != CNT_MAX) begin
        next_perr_cnt = perr_cnt + 8'h01;
      end
    end
    if (reg_rd_i) begin
      if (reg_hit(reg_addr_i, OFF_TEST_CTRL)) begin
        next_rdata[BIT_CHECK_DIS] = check_dis;
        next_rdata[BIT_INJECT] = inject;
        next_rdata[LEN_MSB:LEN_LSB] = match_len;
      end else if (reg_hit(reg_addr_i, OFF_ERR_STATUS)) begin
        next_rdata[BIT_PERR_FLAG] = perr_flag;
      end else if (reg_hit(reg_addr_i, OFF_ERR_REPORT)) begin
        next_rdata[CLASS_MSB:CLASS_LSB] = report_class;
        next_rdata[BIT_IRQ_EN] = irq_en;
      end else if (rd_cnt) begin
        next_rdata[CNT_MSB:CNT_LSB] = perr_cnt;
      end else if (reg_hit(reg_addr_i, OFF_IRQ_MASK)) begin
        next_rdata[BIT_PERR_FLAG] = irq_mask;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      check_dis <= 1'b0;
      inject <= 1'b0;
      match_len <= LEN_RST;
      perr_flag <= 1'b0;
      report_class <= CLASS_RST;
      irq_en <= 1'b0;
      irq_mask <= MASK_RST;
      perr_cnt <= 8'h00;
      rdata <= 32'h0000_0000;
    end else begin
      check_dis <= next_check_dis;
      inject <= next_inject;
      match_len <= next_match_len;
      perr_flag <= next_perr_flag;
      report_class <= next_report_class;
      irq_en <= next_irq_en;
      irq_mask <= next_irq_mask;
      perr_cnt <= next_perr_cnt;
      rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Error message on the rising flag only
  always_comb begin
    next_msg_valid = 1'b0;
    next_msg_class = msg_class;
    if (flag_rise && (report_class != PPEM_REP_NONE)) begin
      next_msg_valid = 1'b1;
      next_msg_class = report_class;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      msg_valid <= 1'b0;
      msg_class <= PPEM_REP_NONE;
    end else begin
      msg_valid <= next_msg_valid;
      msg_class <= next_msg_class;
    end
  end

  // ==========================================================================
  // Generation path toward the core, link and own packets share it
  always_comb begin
    corrupt_now = corrupt_hold;
    if (port_tx_i.sop) begin
      corrupt_now = inject && (port_tx_i.data[HDR_LEN_MSB:HDR_LEN_LSB] == match_len);
    end
  end

  // Decision made at sop holds through eop
  always_comb begin
    next_pkt_state = pkt_state;
    next_corrupt_hold = corrupt_hold;
    if (port_tx_i.valid) begin
      case (pkt_state)
        PPEM_PK_IDLE: begin
          if (port_tx_i.sop && !port_tx_i.eop) begin
            next_pkt_state = PPEM_PK_BODY;
            next_corrupt_hold = corrupt_now;
          end
        end
        PPEM_PK_BODY: begin
          if (port_tx_i.eop) begin
            next_pkt_state = PPEM_PK_IDLE;
            next_corrupt_hold = 1'b0;
          end else if (port_tx_i.sop) begin
            next_corrupt_hold = corrupt_now;
          end
        end
        default: begin
          next_pkt_state = PPEM_PK_IDLE;
          next_corrupt_hold = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    next_tx_q = port_tx_i;
    next_tx_q.par = dw_parity(port_tx_i.data) ^ (port_tx_i.valid && corrupt_now);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pkt_state <= PPEM_PK_IDLE;
      corrupt_hold <= 1'b0;
      tx_q <= '0;
    end else begin
      pkt_state <= next_pkt_state;
      corrupt_hold <= next_corrupt_hold;
      tx_q <= next_tx_q;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_o = rdata;
  assign core_tx_o = tx_q;
  assign err_msg_valid_o = msg_valid;
  assign err_msg_class_o = msg_class;
  // Mask bit one lets the flag through
  assign irq_o = perr_flag && irq_mask && irq_en && upstream_irq_en_i;

endmodule : ppem_monitor

// File: verif/ppem_core_model.sv
// Switch core model: sends double words toward the port with even parity, or odd parity when bad is set
`timescale 1ns/10ps
module ppem_core_model (
  input wire logic clk_i,
  output ppem_pkg::ppem_dw_s core_rx_o
);
  import ppem_pkg::*;
  initial core_rx_o = '0;
  // One double word, then idle with changing data
  task automatic send(input logic [31:0] d, input logic bad);
    @(posedge clk_i);
    core_rx_o <= '{valid: 1'b1, sop: 1'b1, eop: 1'b1, data: d, par: ^d ^ bad};
    @(posedge clk_i);
    core_rx_o <= '{valid: 1'b0, sop: 1'b0, eop: 1'b0, data: ~d, par: ^d};
  endtask : send
endmodule : ppem_core_model

// File: verif/ppem_monitor_asserts.sv
// Checker: port-level assertions of the parity error monitor
`timescale 1ns/10ps
module ppem_monitor_asserts (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ppem_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire ppem_pkg::ppem_dw_s core_rx_i,
  input wire ppem_pkg::ppem_dw_s port_tx_i,
  input wire ppem_pkg::ppem_dw_s core_tx_o,
  input wire logic upstream_irq_en_i,
  input wire logic err_msg_valid_o,
  input wire logic [1:0] err_msg_class_o,
  input wire logic irq_o
);
  import ppem_pkg::*;
  logic [15:0] ctl;
  logic [2:0] rep;
  logic bad_in;
  logic rd_cnt;
  // ==========================================
  // Shadow of the test control and error report fields
  assign bad_in = core_rx_i.valid && !ctl[0] && (core_rx_i.par != ^core_rx_i.data);
  assign rd_cnt = reg_rd_i && (reg_addr_i == OFF_ERR_COUNT);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl <= 16'h0000;
      rep <= 3'h2;
    end else if (reg_wr_i) begin
      if (reg_addr_i == OFF_TEST_CTRL) ctl <= reg_wdata_i[15:0];
      if (reg_addr_i == OFF_ERR_REPORT) rep <= reg_wdata_i[2:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_copy;
    $past(nrst_i) |-> {core_tx_o.valid, core_tx_o.sop, core_tx_o.eop, core_tx_o.data}
      == $past({port_tx_i.valid, port_tx_i.sop, port_tx_i.eop, port_tx_i.data});
  endproperty
  a_copy: assert property (p_copy) else $error("core_tx data not a copy");
  property p_gen;
    core_tx_o.valid && !$past(ctl[1]) |-> core_tx_o.par == ^core_tx_o.data;
  endproperty
  a_gen: assert property (p_gen) else $error("generated parity wrong");
  property p_inj;
    core_tx_o.valid && core_tx_o.sop && $past(ctl[1]) && core_tx_o.data[31:24] == $past(ctl[15:8])
      |-> core_tx_o.par != ^core_tx_o.data;
  endproperty
  a_inj: assert property (p_inj) else $error("parity not corrupted");
  property p_msg_cause;
    err_msg_valid_o |-> $past(bad_in) ##1 !err_msg_valid_o;
  endproperty
  a_msg_cause: assert property (p_msg_cause) else $error("message without error");
  property p_msg_class;
    err_msg_valid_o |-> err_msg_class_o == $past(rep[1:0]) && $past(rep[1:0]) != 2'h0;
  endproperty
  a_msg_class: assert property (p_msg_class) else $error("message class wrong");
  property p_no_check;
    ctl[0] |=> !err_msg_valid_o;
  endproperty
  a_no_check: assert property (p_no_check) else $error("error while disabled");
  property p_irq;
    irq_o |-> rep[2] && upstream_irq_en_i;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not enabled");
  property p_cnt_clr;
    (rd_cnt && !bad_in) ##1 rd_cnt |=> reg_rdata_o == 32'h0;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared");
endmodule : ppem_monitor_asserts

bind ppem_monitor ppem_monitor_asserts u_chk (.clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .core_rx_i, .port_tx_i, .core_tx_o, .upstream_irq_en_i,
  .err_msg_valid_o, .err_msg_class_o, .irq_o);

// File: verif/testbench.sv
// Testbench: registers, checking, reporting and generation of the monitor
`timescale 1ns/10ps
module testbench;
  import ppem_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic up_en = 1'b0;
  logic [31:0] reg_rdata_o;
  ppem_dw_s core_rx;
  ppem_dw_s port_tx = '0;
  ppem_dw_s core_tx_o;
  logic err_msg_valid_o;
  logic irq_o;
  logic [1:0] err_msg_class_o;
  int n_errors = 0;
  int n_compared = 0;
  int n_msg = 0;
  int m;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (err_msg_valid_o === 1'b1) n_msg++;
  ppem_monitor uut (.clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .core_rx_i(core_rx), .port_tx_i(port_tx), .core_tx_o,
    .upstream_irq_en_i(up_en), .err_msg_valid_o, .err_msg_class_o, .irq_o);
  ppem_core_model core (.clk_i, .core_rx_o(core_rx));
  // ==========================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("rdata", exp, reg_rdata_o);
  endtask : rd
  task automatic err(input int n);
    repeat (n) core.send(32'h1234_5678, 1'b1);
    repeat (2) @(posedge clk_i);
    #1;
  endtask : err
  task automatic tx(input logic [31:0] d, input logic s, input logic e, input logic bad);
    @(posedge clk_i);
    port_tx <= '{valid: 1'b1, sop: s, eop: e, data: d, par: 1'b0};
    @(posedge clk_i);
    port_tx <= '0;
    #1 chk("tx_par", {31'h0, ^d ^ bad}, {31'h0, core_tx_o.par});
  endtask : tx
  task automatic wrap_up;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // ==========================================
  // Sequence
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    up_en <= 1'b1;
    rd(OFF_TEST_CTRL, 32'h0);
    rd(OFF_ERR_STATUS, 32'h0);
    rd(OFF_ERR_REPORT, 32'h2);
    rd(OFF_ERR_COUNT, 32'h0);
    rd(12'h4e4, 32'h0);
    wr(OFF_IRQ_MASK, 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(OFF_ERR_REPORT, 32'(c) | (32'(c % 2) << 2));
      m = n_msg;
      err(2);
      chk("msgs", 32'(c != 0), 32'(n_msg - m));
      chk("irq", 32'(c % 2), {31'h0, irq_o});
      chk("class", 32'(c), {30'h0, err_msg_class_o});
      if (c == 3) begin
        @(posedge clk_i);
        up_en <= 1'b0;
        @(posedge clk_i);
        #1 chk("irq_up_off", 32'h0, {31'h0, irq_o});
        @(posedge clk_i);
        up_en <= 1'b1;
      end
      rd(OFF_ERR_STATUS, 32'h1);
      wr(OFF_ERR_STATUS, 32'h1);
      chk("irq_clr", 32'h0, {31'h0, irq_o});
    end
    rd(OFF_ERR_COUNT, 32'h8);
    wr(OFF_ERR_REPORT, 32'h2);
    err(260);
    @(posedge clk_i);
    reg_addr_i <= OFF_ERR_COUNT;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    #1 chk("count_sat", 32'hff, reg_rdata_o);
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("count_clr", 32'h0, reg_rdata_o);
    wr(OFF_ERR_STATUS, 32'h1);
    wr(OFF_TEST_CTRL, 32'hffff_ffff);
    rd(OFF_TEST_CTRL, 32'h0000_ff03);
    m = n_msg;
    err(1);
    rd(OFF_ERR_STATUS, 32'h0);
    rd(OFF_ERR_COUNT, 32'h0);
    chk("msg_off", 32'h0, 32'(n_msg - m));
    tx(32'hff00_0001, 1'b1, 1'b0, 1'b1);
    tx(32'h0000_0003, 1'b0, 1'b0, 1'b1);
    tx(32'h7f00_0000, 1'b0, 1'b1, 1'b1);
    tx(32'h7f00_0001, 1'b1, 1'b1, 1'b0);
    wr(OFF_TEST_CTRL, 32'h0000_ff00);
    tx(32'hff00_0007, 1'b1, 1'b1, 1'b0);
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    wrap_up;
  end
endmodule : testbench
